// ==== fbpo_bridge_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// gate drives of an external full bridge; counts what the filament sees
module fbpo_bridge_model (
    // clock and bench control
    input  wire logic  clk,
    input  wire logic  clr,
    // gate drives from the device
    input  wire logic  gate_a,
    input  wire logic  gate_b,
    // load observations
    output logic [15:0] shoot_cnt,
    output logic [15:0] fwd_cnt,
    output logic [15:0] rev_cnt
);
    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            shoot_cnt <= 16'h0000;
            fwd_cnt   <= 16'h0000;
            rev_cnt   <= 16'h0000;
        end
        else
        begin
            // both legs on shorts the supply through the bridge
            if (gate_a && gate_b)
                shoot_cnt <= shoot_cnt + 16'h0001;
            if (gate_b && !gate_a)
                fwd_cnt <= fwd_cnt + 16'h0001;
            if (gate_a && !gate_b)
                rev_cnt <= rev_cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== fbpo_fil_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbpo_fil_seq
    import fbpo_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // timing and setting
    input  wire logic       digit_start,
    input  wire logic [7:0] duty_cfg,
    // drive and state
    output logic            drive_a,
    output logic            drive_b,
    output logic [8:0]      period_cnt,
    output logic [7:0]      duty_used,
    output fbpo_region_e    region
);
    typedef struct packed {
        logic [8:0]   cnt;
        logic [7:0]   duty;
        fbpo_region_e region;
    } fbpo_seq_s;

    fbpo_seq_s st;
    fbpo_seq_s next_st;

    function automatic fbpo_region_e region_of(input logic [8:0] c, input logic [7:0] d);
        logic [8:0] b_start;
        logic [8:0] a_end;
        b_start = GAP_START - {1'b0, d};
        a_end   = GAP_END + {1'b0, d};
        if (c < b_start)
            region_of = RG_IDLE_HEAD;
        else if (c < GAP_START)
            region_of = RG_DRIVE_B;
        else if (c < GAP_END)
            region_of = RG_GAP;
        else if (c < a_end)
            region_of = RG_DRIVE_A;
        else
            region_of = RG_IDLE_TAIL;
    endfunction

    always_comb
    begin
        next_st = st;
        if (digit_start || st.cnt == PERIOD_LAST)
            next_st.cnt = '0;
        else
            next_st.cnt = st.cnt + 9'h001;
        // duty only changes at a period boundary so a period never tears
        if (next_st.cnt == '0)
            next_st.duty = (duty_cfg > DUTY_MAX) ? DUTY_MAX : duty_cfg;
        next_st.region = region_of(next_st.cnt, next_st.duty);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '{cnt: 9'h000, duty: 8'h00, region: RG_IDLE_HEAD};
        else
            st <= next_st;
    end

    assign drive_a    = (st.region == RG_DRIVE_A);
    assign drive_b    = (st.region == RG_DRIVE_B);
    assign period_cnt = st.cnt;
    assign duty_used  = st.duty;
    assign region     = st.region;
endmodule
`default_nettype wire

// ==== fbpo_pkg.sv ====
package fbpo_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DUTY        = 8'h09;
    localparam logic [7:0] IDX_SEL_A       = 8'h0A;
    localparam logic [7:0] IDX_SEL_B       = 8'h0B;
    localparam logic [7:0] IDX_PORT_FIRST  = 8'h0C;
    localparam logic [7:0] IDX_PORT_SECOND = 8'h0D;
    localparam logic [7:0] IDX_STATUS      = 8'h0E;

    // status register bit positions
    localparam int unsigned ST_SHDN   = 0;
    localparam int unsigned ST_OUT_A  = 1;
    localparam int unsigned ST_OUT_B  = 2;
    localparam int unsigned ST_PORT_F = 3;
    localparam int unsigned ST_PORT_S = 4;
    localparam int unsigned ST_REGION = 5;

    typedef enum logic [1:0] {
        PH_LOW   = 2'h0,
        PH_HIGH  = 2'h1,
        PH_BLINK = 2'h2,
        PH_FIL   = 2'h3
    } fbpo_phase_fn_e;

    typedef enum logic [2:0] {
        PT_LOW   = 3'h0,
        PT_HIGH  = 3'h1,
        PT_BLINK = 3'h2,
        PT_DOUT  = 3'h3,
        PT_TONE0 = 3'h4,
        PT_TONE1 = 3'h5,
        PT_TONE2 = 3'h6,
        PT_RUN   = 3'h7
    } fbpo_port_fn_e;

    // gray along the period
    typedef enum logic [2:0] {
        RG_IDLE_HEAD = 3'h0,
        RG_DRIVE_B   = 3'h1,
        RG_GAP       = 3'h3,
        RG_DRIVE_A   = 3'h2,
        RG_IDLE_TAIL = 3'h6
    } fbpo_region_e;

    // reset values
    localparam logic [7:0] RST_DUTY        = 8'h00;
    localparam logic [1:0] RST_SEL_A       = 2'h0;
    localparam logic [1:0] RST_SEL_B       = 2'h0;
    localparam logic [2:0] RST_PORT_FIRST  = 3'h0;
    localparam logic [2:0] RST_PORT_SECOND = 3'h1;

    // filament timing in oscillator cycles
    localparam int unsigned PERIOD_CYCLES = 400;
    localparam logic [8:0]  PERIOD_LAST   = 9'(PERIOD_CYCLES - 1);
    localparam logic [7:0]  DUTY_MAX      = 8'hC7;
    localparam int unsigned GAP_CYCLES    = 2;
    localparam logic [8:0]  GAP_START     = 9'(DUTY_MAX);
    localparam logic [8:0]  GAP_END       = 9'(DUTY_MAX + GAP_CYCLES);

    // tones, derived from the nominal oscillator
    localparam int unsigned OSC_NOM_HZ = 4000000;
    localparam int unsigned TONE0_HZ   = 625;
    localparam int unsigned TONE1_HZ   = 1250;
    localparam int unsigned TONE2_HZ   = 2500;
    localparam logic [11:0] TONE0_HALF = 12'(OSC_NOM_HZ / (2 * TONE0_HZ));
    localparam logic [11:0] TONE1_HALF = 12'(OSC_NOM_HZ / (2 * TONE1_HZ));
    localparam logic [11:0] TONE2_HALF = 12'(OSC_NOM_HZ / (2 * TONE2_HZ));
endpackage

// ==== fbpo_tones.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbpo_tones
    import fbpo_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // square waves, lowest first
    output logic [2:0] tone
);
    localparam logic [2:0][11:0] HALF = {TONE2_HALF, TONE1_HALF, TONE0_HALF};

    typedef struct packed {
        logic [2:0][11:0] cnt;
        logic [2:0]       tone;
    } fbpo_tone_s;

    fbpo_tone_s st;
    fbpo_tone_s next_st;

    always_comb
    begin
        next_st = st;
        for (int i = 0; i < 3; i++)
        begin
            if (st.cnt[i] == HALF[i] - 12'h001)
            begin
                next_st.cnt[i]  = '0;
                next_st.tone[i] = ~st.tone[i];
            end
            else
                next_st.cnt[i] = st.cnt[i] + 12'h001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign tone = st.tone;
endmodule
`default_nettype wire

// ==== fbpo_top.sv ====
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module fbpo_top
    import fbpo_pkg::*;
#(
    parameter int unsigned ADDR_W = 10
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // device state from the rest of the controller
    input  wire logic              shutdown,
    input  wire logic              blink_phase,
    input  wire logic              serial_dout,
    input  wire logic              digit_start,
    // output pins
    output logic                   bridge_out_a,
    output logic                   bridge_out_b,
    output logic                   port_out_first,
    output logic                   port_out_second
);
    typedef struct packed {
        logic [7:0]     duty;
        fbpo_phase_fn_e sel_a;
        fbpo_phase_fn_e sel_b;
        fbpo_port_fn_e  sel_pf;
        fbpo_port_fn_e  sel_ps;
        logic           out_a;
        logic           out_b;
        logic           out_pf;
        logic           out_ps;
        logic [31:0]    rdata;
    } fbpo_top_s;

    localparam fbpo_top_s ST_RESET = '{
        duty:   RST_DUTY,
        sel_a:  fbpo_phase_fn_e'(RST_SEL_A),
        sel_b:  fbpo_phase_fn_e'(RST_SEL_B),
        sel_pf: fbpo_port_fn_e'(RST_PORT_FIRST),
        sel_ps: fbpo_port_fn_e'(RST_PORT_SECOND),
        out_a:  1'b0,
        out_b:  1'b0,
        out_pf: 1'b0,
        out_ps: 1'b1,
        rdata:  32'h0000_0000
    };

    fbpo_top_s st;
    fbpo_top_s next_st;

    logic         seq_a;
    logic         seq_b;
    logic [8:0]   period_cnt;
    logic [7:0]   duty_used;
    fbpo_region_e region;
    logic [2:0]   tone;
    logic [7:0]   idx;
    logic         setup;
    logic         wr_go;

    fbpo_fil_seq u_seq (
        .clk         (clk),
        .rst         (rst),
        .digit_start (digit_start),
        .duty_cfg    (st.duty),
        .drive_a     (seq_a),
        .drive_b     (seq_b),
        .period_cnt  (period_cnt),
        .duty_used   (duty_used),
        .region      (region)
    );

    fbpo_tones u_tones (
        .clk  (clk),
        .rst  (rst),
        .tone (tone)
    );

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = 8'(a >> 2);
        reg_hit = (a[1:0] == 2'h0) && (i >= IDX_DUTY) && (i <= IDX_STATUS);
    endfunction

    function automatic logic phase_out(
        input fbpo_phase_fn_e sel,
        input logic           blink,
        input logic           fil,
        input logic           shdn
    );
        case (sel)
            PH_LOW:   phase_out = 1'b0;
            PH_HIGH:  phase_out = 1'b1;
            PH_BLINK: phase_out = blink;
            PH_FIL:   phase_out = fil & ~shdn;
            default:  phase_out = 1'b0;
        endcase
    endfunction

    // the second port flips only the tone and shutdown functions
    function automatic logic port_out(
        input fbpo_port_fn_e sel,
        input logic          blink,
        input logic          dout,
        input logic [2:0]    tn,
        input logic          shdn,
        input logic          inv
    );
        logic t;
        t = 1'b0;
        case (sel)
            PT_LOW:   port_out = 1'b0;
            PT_HIGH:  port_out = 1'b1;
            PT_BLINK: port_out = blink;
            PT_DOUT:  port_out = dout;
            PT_TONE0, PT_TONE1, PT_TONE2:
            begin
                t = tn[sel[1:0]] & ~shdn;
                port_out = t ^ inv;
            end
            PT_RUN:   port_out = ~shdn ^ inv;
            default:  port_out = 1'b0;
        endcase
    endfunction

    assign idx   = 8'(paddr >> 2);
    assign setup = psel & ~penable;
    assign wr_go = psel & penable & pwrite & pstrb[0] & reg_hit(paddr);

    always_comb
    begin
        next_st = st;
        // read data is captured in the setup cycle so prdata comes from a flop
        if (setup)
        begin
            next_st.rdata = 32'h0000_0000;
            case (idx)
                IDX_DUTY:        next_st.rdata[7:0] = st.duty;
                IDX_SEL_A:       next_st.rdata[1:0] = st.sel_a;
                IDX_SEL_B:       next_st.rdata[1:0] = st.sel_b;
                IDX_PORT_FIRST:  next_st.rdata[2:0] = st.sel_pf;
                IDX_PORT_SECOND: next_st.rdata[2:0] = st.sel_ps;
                IDX_STATUS:
                begin
                    next_st.rdata[ST_SHDN]             = shutdown;
                    next_st.rdata[ST_OUT_A]            = st.out_a;
                    next_st.rdata[ST_OUT_B]            = st.out_b;
                    next_st.rdata[ST_PORT_F]           = st.out_pf;
                    next_st.rdata[ST_PORT_S]           = st.out_ps;
                    next_st.rdata[ST_REGION+2:ST_REGION] = region;
                end
                default:         next_st.rdata = 32'h0000_0000;
            endcase
            if (!reg_hit(paddr))
                next_st.rdata = 32'h0000_0000;
        end
        if (wr_go)
        begin
            case (idx)
                IDX_DUTY:        next_st.duty   = pwdata[7:0];
                IDX_SEL_A:       next_st.sel_a  = fbpo_phase_fn_e'(pwdata[1:0]);
                IDX_SEL_B:       next_st.sel_b  = fbpo_phase_fn_e'(pwdata[1:0]);
                IDX_PORT_FIRST:  next_st.sel_pf = fbpo_port_fn_e'(pwdata[2:0]);
                IDX_PORT_SECOND: next_st.sel_ps = fbpo_port_fn_e'(pwdata[2:0]);
                default:         next_st.duty   = st.duty;
            endcase
        end
        next_st.out_a  = phase_out(st.sel_a, blink_phase, seq_a, shutdown);
        next_st.out_b  = phase_out(st.sel_b, blink_phase, seq_b, shutdown);
        next_st.out_pf = port_out(st.sel_pf, blink_phase, serial_dout, tone, shutdown, 1'b0);
        next_st.out_ps = port_out(st.sel_ps, blink_phase, serial_dout, tone, shutdown, 1'b1);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= ST_RESET;
        else
            st <= next_st;
    end

    // zero wait states: the access cycle always completes
    assign pready          = psel & penable;
    assign pslverr         = psel & penable & ~reg_hit(paddr);
    assign prdata          = st.rdata;
    assign bridge_out_a    = st.out_a;
    assign bridge_out_b    = st.out_b;
    assign port_out_first  = st.out_pf;
    assign port_out_second = st.out_ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic [8:0] b_start;
    logic [8:0] a_end;
    assign b_start = GAP_START - {1'b0, duty_used};
    assign a_end   = GAP_END + {1'b0, duty_used};

    chk_idle_low: assert property (
        (period_cnt < b_start || period_cnt >= a_end) |-> !seq_a && !seq_b
    ) else $error("bridge drive active in idle interval");

    chk_drive_b: assert property (
        (period_cnt >= b_start && period_cnt < GAP_START) |-> seq_b && !seq_a
    ) else $error("output B drive interval wrong");

    chk_gap_two: assert property (
        ($fell(seq_b) && duty_used != 8'h00 && period_cnt == GAP_START)
        |-> (!seq_a && !seq_b) [*2] ##1 seq_a
    ) else $error("commutation gap not two cycles");

    chk_drive_a: assert property (
        $rose(seq_a) |-> period_cnt == GAP_END && !seq_b
    ) else $error("output A drive misplaced");

    chk_period_wrap: assert property (
        (period_cnt == PERIOD_LAST) |=> period_cnt == 9'h000
    ) else $error("filament period not 400 cycles");

    chk_duty_range: assert property (
        duty_used <= DUTY_MAX
    ) else $error("duty above maximum used");

    chk_fil_shdn: assert property (
        (st.sel_a == PH_FIL && shutdown) |=> !bridge_out_a
    ) else $error("output A driven in shutdown");

    chk_b_follows: assert property (
        (st.sel_b == PH_FIL && !shutdown) |=> bridge_out_b == $past(seq_b)
    ) else $error("output B not following drive");

    chk_blink_sel: assert property (
        (st.sel_a == PH_BLINK) |=> bridge_out_a == $past(blink_phase)
    ) else $error("output A blink mismatch");

    chk_reset_outs: assert property (
        $past(rst) |-> st.sel_a == PH_LOW && st.sel_b == PH_LOW
            && !bridge_out_a && !port_out_first && port_out_second
    ) else $error("reset state of outputs wrong");

    chk_tone_shdn: assert property (
        (st.sel_ps inside {PT_TONE0, PT_TONE1, PT_TONE2} && shutdown) |=> port_out_second
    ) else $error("second port tone not high in shutdown");

    chk_run_status: assert property (
        (st.sel_pf == PT_RUN) |=> port_out_first == !$past(shutdown)
    ) else $error("first port shutdown status wrong");

    chk_digit_lock: assert property (
        digit_start |=> period_cnt == 9'h000
    ) else $error("period not restarted on digit start");

    cov_full_period: cover property (
        $rose(seq_b) ##[1:300] $rose(seq_a)
    );
    cov_fil_write: cover property (
        wr_go && idx == IDX_SEL_A && pwdata[1:0] == PH_FIL
    );
    cov_tone_bridge: cover property (
        st.sel_pf == PT_TONE0 && st.sel_ps == PT_TONE2 && !shutdown
    );
    cov_unmapped: cover property (
        pslverr
    );
endmodule
`default_nettype wire

// ==== fbpo_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbpo_top_bench
    import fbpo_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        shutdown;
    logic        blink_phase;
    logic        serial_dout;
    logic        digit_start;
    logic        out_a;
    logic        out_b;
    logic        pf;
    logic        ps;
    logic        clr;
    logic [15:0] shoot_cnt;
    logic [15:0] fwd_cnt;
    logic [15:0] rev_cnt;
    int          error_cnt;
    int          checks;
    int          tone_hz [3] = '{625, 1250, 2500};

    fbpo_top #(.ADDR_W(10)) dut_u (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .shutdown(shutdown),
        .blink_phase(blink_phase), .serial_dout(serial_dout),
        .digit_start(digit_start), .bridge_out_a(out_a), .bridge_out_b(out_b),
        .port_out_first(pf), .port_out_second(ps)
    );

    fbpo_bridge_model load_u (
        .clk(clk), .clr(clr), .gate_a(out_a), .gate_b(out_b),
        .shoot_cnt(shoot_cnt), .fwd_cnt(fwd_cnt), .rev_cnt(rev_cnt)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop;
        begin
            if (error_cnt == 0 && checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            checks++;
            if (seen !== exp)
            begin
                error_cnt++;
                $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
            end
        end
    endtask

    // entered right after a rising edge; one idle edge follows the closing edge so the
    // next call never re-drives psel in the time step that released it
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        begin
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= wd;
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (pready !== 1'b1 && n < 16);
            if (pready !== 1'b1)
            begin
                error_cnt++;
                report_and_stop();
            end
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        begin
            apb(1'b1, {idx, 2'b00}, d, r, e);
        end
    endtask

    task automatic xchk(input string nm, input logic w, input logic [9:0] a,
                        input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        begin
            apb(w, a, exp, r, e);
            if (!w)
                check(nm, r, exp);
            check("pslverr", 32'(e), 32'(exp_err));
        end
    endtask

    task automatic wait_toggle(output int n);
        logic prev;
        begin
            @(negedge clk);
            prev = pf;
            n = 1;
            while (pf === prev && n < 8000)
            begin
                @(negedge clk);
                n++;
            end
            if (pf === prev)
            begin
                error_cnt++;
                report_and_stop();
            end
        end
    endtask

    task automatic fil_run(input int d, input logic s);
        int   dc;
        int   c;
        logic ea;
        logic eb;
        begin
            wr(IDX_DUTY, 32'(d));
            wr(IDX_SEL_A, 32'h0000_0003);
            wr(IDX_SEL_B, 32'h0000_0003);
            shutdown    <= s;
            clr         <= 1'b1;
            digit_start <= 1'b1;
            @(posedge clk);
            digit_start <= 1'b0;
            @(posedge clk);
            clr <= 1'b0;
            // duty above the top code behaves as the top code
            dc = (d > 199) ? 199 : d;
            for (int i = 1; i <= 600; i++)
            begin
                @(negedge clk);
                c = (i - 1) % 400;
                eb = !s && c >= 199 - dc && c < 199;
                ea = !s && c >= 201 && c < 201 + dc;
                check("bridge_out_b", 32'(out_b), 32'(eb));
                check("bridge_out_a", 32'(out_a), 32'(ea));
                if (i == 401)
                begin
                    check("shoot_cnt", 32'(shoot_cnt), 32'h0);
                    check("fwd_cnt", 32'(fwd_cnt), s ? 32'h0 : 32'(dc));
                    check("rev_cnt", 32'(rev_cnt), s ? 32'h0 : 32'(dc));
                end
            end
            @(posedge clk);
        end
    endtask

    initial
    begin
        int   n;
        logic ea;
        logic ef;
        logic es;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        shutdown = 1'b0;
        blink_phase = 1'b0;
        serial_dout = 1'b0;
        digit_start = 1'b0;
        clr = 1'b1;
        error_cnt = 0;
        checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("bridge_out_a", 32'(out_a), 32'h0);
        check("bridge_out_b", 32'(out_b), 32'h0);
        check("port_out_first", 32'(pf), 32'h0);
        check("port_out_second", 32'(ps), 32'h1);
        @(posedge clk);
        xchk("sel_a", 1'b0, {IDX_SEL_A, 2'b00}, 32'h0, 1'b0);
        xchk("sel_b", 1'b0, {IDX_SEL_B, 2'b00}, 32'h0, 1'b0);
        xchk("port_second", 1'b0, {IDX_PORT_SECOND, 2'b00}, 32'h1, 1'b0);
        // duty still zero here, so the sequencer sits in head idle
        xchk("status", 1'b0, {IDX_STATUS, 2'b00}, 32'h0000_0010, 1'b0);
        wr(IDX_DUTY, 32'hFFFF_FFC7);
        xchk("duty", 1'b0, {IDX_DUTY, 2'b00}, 32'h0000_00C7, 1'b0);
        pstrb <= 4'h0;
        wr(IDX_DUTY, 32'h0000_0055);
        pstrb <= 4'hF;
        xchk("bad_addr", 1'b1, 10'h025, 32'h0000_0011, 1'b1);
        xchk("duty", 1'b0, {IDX_DUTY, 2'b00}, 32'h0000_00C7, 1'b0);
        xchk("unmapped", 1'b0, 10'h3FC, 32'h0, 1'b1);
        for (int c = 0; c < 8; c++)
        begin
            // upper bits set on purpose; only the low code may count
            wr(IDX_SEL_A, 32'(c) | 32'h0000_00F8);
            wr(IDX_SEL_B, 32'(c) | 32'h0000_00F8);
            wr(IDX_PORT_FIRST, 32'(c) | 32'h0000_00F8);
            wr(IDX_PORT_SECOND, 32'(c) | 32'h0000_00F8);
            xchk("sel_a", 1'b0, {IDX_SEL_A, 2'b00}, 32'(c % 4), 1'b0);
            xchk("port_first", 1'b0, {IDX_PORT_FIRST, 2'b00}, 32'(c), 1'b0);
            for (int v = 0; v < 8; v++)
            begin
                shutdown    <= v[0];
                blink_phase <= v[1];
                serial_dout <= v[2];
                repeat (2) @(negedge clk);
                ea = (c % 4 == 1) || (c % 4 == 2 && v[1]);
                if (c % 4 != 3 || v[0])
                begin
                    check("bridge_out_a", 32'(out_a), 32'(ea));
                    check("bridge_out_b", 32'(out_b), 32'(ea));
                end
                case (c)
                    1: ef = 1'b1;
                    2: ef = v[1];
                    3: ef = v[2];
                    7: ef = !v[0];
                    default: ef = 1'b0;
                endcase
                es = (c >= 4) ? !ef : ef;
                if (c >= 4 && c < 7 && !v[0])
                    es = !pf;
                if (c < 4 || c == 7 || v[0])
                    check("port_out_first", 32'(pf), 32'(ef));
                check("port_out_second", 32'(ps), 32'(es));
                @(posedge clk);
            end
        end
        shutdown <= 1'b0;
        for (int t = 0; t < 3; t++)
        begin
            wr(IDX_PORT_FIRST, 32'(4 + t));
            wait_toggle(n);
            wait_toggle(n);
            check("tone_half", 32'(n), 32'(4000000 / (2 * tone_hz[t])));
            @(posedge clk);
        end
        fil_run(1, 1'b0);
        fil_run(100, 1'b0);
        fil_run(199, 1'b0);
        fil_run(250, 1'b0);
        fil_run(0, 1'b0);
        fil_run(100, 1'b1);
        shutdown <= 1'b0;
        wr(IDX_SEL_A, 32'h0);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (401) @(posedge clk);
        @(negedge clk);
        check("rev_cnt", 32'(rev_cnt), 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
